// ===== rtl/rtc_pkg.sv
// Constants and the bus request carrier type for the real-time clock timer.
package rtc_pkg;
	localparam logic [7:0] seconds_off = 8'h00;
	localparam logic [7:0] minutes_off = 8'h04;
	localparam logic [7:0] hours_off = 8'h08;
	localparam logic [7:0] weekday_off = 8'h0c;
	localparam logic [7:0] ctl_one_off = 8'h10;
	localparam logic [7:0] ctl_two_off = 8'h14;
	localparam logic [7:0] status_off = 8'h18;
	localparam logic [7:0] mask_off = 8'h1c;
	localparam logic [7:0] csel_off = 8'h20;
	localparam int run_bit = 0;
	localparam int running_bit = 1;
	localparam int busy_bit = 2;
	localparam int h24_bit = 5;
	localparam int pm_bit = 6;
	localparam int ev_update = 0;
	localparam int ev_run_change = 1;
	localparam int clk_khz = 40000;
	localparam int busy_time_us = 62500;
	localparam int busy_cycles = busy_time_us / 1000 * clk_khz + busy_time_us % 1000 * clk_khz / 1000;
	localparam int ticks_per_sec = 256;
	localparam logic [5:0] sec_max = 6'h3b;
	localparam logic [4:0] hr24_max = 5'h17;
	localparam logic [4:0] hr12_max = 5'h0b;
	localparam logic [2:0] wk_max = 3'h6;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_s;
endpackage : rtc_pkg

// ===== rtl/rtc_timer.sv
// Real-time clock timer with Wishbone register access.
`timescale 1ns/1ps
`default_nettype none
module rtc_timer
	import rtc_pkg::*;
#(
	parameter int busy_len = busy_cycles,
	parameter int tick_div = ticks_per_sec
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic count_tick,
	input wire wb_req_s wb_req,
	output logic wb_ack,
	output logic [31:0] wb_dat,
	output logic irq
);

	//////////////////////////////////////////////////////////////////
	// All state of the block, registered as one word.
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic irq;
		logic count_run_request;
		logic sync_first;
		logic count_running_flag;
		logic running_seen;
		logic [5:0] seconds_value;
		logic [5:0] minutes_value;
		logic [4:0] hours_value;
		logic [2:0] weekday_value;
		logic hour_format_select;
		logic afternoon_flag;
		logic [7:0] clock_control_two;
		logic [3:0] clock_select_bits;
		logic [1:0] status;
		logic [1:0] mask;
		logic [15:0] presc;
		logic update_in_progress_flag;
		logic [31:0] busy_cnt;
	} state_s;

	state_s q;
	state_s d;

	//////////////////////////////////////////////////////////////////
	// Counter step that wraps to zero past its top value.
	function automatic logic [5:0] wrap_inc(input logic [5:0] v, input logic [5:0] top);
		wrap_inc = (v >= top) ? 6'h00 : v + 6'h01;
	endfunction : wrap_inc

	//////////////////////////////////////////////////////////////////
	// Decode helpers filled at the top of the next state logic.
	logic [31:0] ctl_one_rd;
	logic access;
	logic wr_en;
	logic rd_en;
	logic [1:0] events;
	logic [4:0] hr_top;
	logic [5:0] hr_next;

	always_comb begin
		d = q;
		events = 2'h0;
		access = wb_req.cyc && wb_req.stb && !q.ack;
		wr_en = access && wb_req.we && wb_req.sel[0];
		rd_en = access && !wb_req.we;
		ctl_one_rd = 32'h0;
		ctl_one_rd[run_bit] = q.count_run_request;
		ctl_one_rd[running_bit] = q.count_running_flag;
		ctl_one_rd[busy_bit] = q.update_in_progress_flag;
		ctl_one_rd[h24_bit] = q.hour_format_select;
		ctl_one_rd[pm_bit] = q.afternoon_flag;
		hr_top = q.hour_format_select ? hr24_max : hr12_max;
		hr_next = wrap_inc({1'b0, q.hours_value}, {1'b0, hr_top});
		d.ack = access;
		//////////////////////////////////////////////////////////////////
		// Start request synchroniser, clocked by count-source ticks.
		if (count_tick) begin
			d.sync_first = q.count_run_request;
			d.count_running_flag = q.sync_first;
		end
		// Change of the running flag is seen from its own delayed copy.
		d.running_seen = q.count_running_flag;
		if (q.running_seen != q.count_running_flag) begin
			events[ev_run_change] = 1'b1;
		end
		//////////////////////////////////////////////////////////////////
		// Time base and update with busy window.
		if (count_tick && q.count_running_flag && !q.update_in_progress_flag) begin
			if (32'(q.presc) >= tick_div - 1) begin
				d.presc = 16'h0;
				d.update_in_progress_flag = 1'b1;
				d.busy_cnt = 32'h0;
			end else begin
				d.presc = q.presc + 16'h1;
			end
		end
		if (q.update_in_progress_flag) begin
			if (q.busy_cnt >= 32'(busy_len - 1)) begin
				d.update_in_progress_flag = 1'b0;
				events[ev_update] = 1'b1;
				d.seconds_value = wrap_inc(q.seconds_value, sec_max);
				if (q.seconds_value == sec_max) begin
					d.minutes_value = wrap_inc(q.minutes_value, sec_max);
					if (q.minutes_value == sec_max) begin
						d.hours_value = hr_next[4:0];
						if (q.hours_value == hr_top) begin
							if (!q.hour_format_select) begin
								d.afternoon_flag = !q.afternoon_flag;
							end
							if (q.hour_format_select || q.afternoon_flag) begin
								if (q.weekday_value >= wk_max) begin
									d.weekday_value = 3'h0;
								end else begin
									d.weekday_value = q.weekday_value + 3'h1;
								end
							end
						end
					end
				end
			end else begin
				d.busy_cnt = q.busy_cnt + 32'h1;
			end
		end
		//////////////////////////////////////////////////////////////////
		// Register access.
		if (wr_en) begin
			if (wb_req.adr == seconds_off) begin
				d.seconds_value = wb_req.dat[5:0];
			end else if (wb_req.adr == minutes_off) begin
				d.minutes_value = wb_req.dat[5:0];
			end else if (wb_req.adr == hours_off) begin
				d.hours_value = wb_req.dat[4:0];
			end else if (wb_req.adr == weekday_off) begin
				d.weekday_value = wb_req.dat[2:0];
			end else if (wb_req.adr == ctl_one_off) begin
				d.count_run_request = wb_req.dat[run_bit];
				d.hour_format_select = wb_req.dat[h24_bit];
				d.afternoon_flag = wb_req.dat[pm_bit];
			end else if (wb_req.adr == ctl_two_off) begin
				d.clock_control_two = wb_req.dat[7:0];
			end else if (wb_req.adr == status_off) begin
				d.status = q.status & ~wb_req.dat[1:0];
			end else if (wb_req.adr == mask_off) begin
				d.mask = wb_req.dat[1:0];
			end else if (wb_req.adr == csel_off) begin
				d.clock_select_bits = wb_req.dat[3:0];
			end
		end

		// A hardware event wins over a clear written in the same cycle.
		d.status = d.status | events;

		//////////////////////////////////////////////////////////////////
		// Read data, loaded in the cycle in which the access is taken.
		if (rd_en) begin
			if (wb_req.adr == seconds_off) begin
				d.rdat = {26'h0, q.seconds_value};
			end else if (wb_req.adr == minutes_off) begin
				d.rdat = {26'h0, q.minutes_value};
			end else if (wb_req.adr == hours_off) begin
				d.rdat = {27'h0, q.hours_value};
			end else if (wb_req.adr == weekday_off) begin
				d.rdat = {29'h0, q.weekday_value};
			end else if (wb_req.adr == ctl_one_off) begin
				d.rdat = ctl_one_rd;
			end else if (wb_req.adr == ctl_two_off) begin
				d.rdat = {24'h0, q.clock_control_two};
			end else if (wb_req.adr == status_off) begin
				d.rdat = {30'h0, q.status};
			end else if (wb_req.adr == mask_off) begin
				d.rdat = {30'h0, q.mask};
			end else if (wb_req.adr == csel_off) begin
				d.rdat = {28'h0, q.clock_select_bits};
			end else begin
				d.rdat = 32'h0;
			end
		end
		d.irq = |(d.status & d.mask);
	end

	//////////////////////////////////////////////////////////////////
	// State register, frozen while the clock enable is low and rst_n is high; reset clears it whatever the clock enable.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			q <= '0;
		end else if (clk_en) begin
			q <= d;
		end
	end

	//////////////////////////////////////////////////////////////////
	// Outputs are plain copies of registered state.
	assign wb_ack = q.ack;
	assign wb_dat = q.rdat;
	assign irq = q.irq;

endmodule : rtc_timer
`default_nettype wire

// ===== tb/rtc_timer_props.sv
// Port assertions for the real-time clock timer.
`timescale 1ns/1ps
`default_nettype none
module rtc_timer_props
	import rtc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic count_tick,
	input wire wb_req_s wb_req,
	input wire logic wb_ack,
	input wire logic [31:0] wb_dat,
	input wire logic irq
);
	wire logic req = wb_req.cyc && wb_req.stb;
	wire logic rd_take = req && !wb_ack && clk_en && !wb_req.we;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_ACK_NEXT: assert property (req && !wb_ack && clk_en |=> wb_ack) else $error("no ack");
	AST_ACK_PULSE: assert property (wb_ack && clk_en |=> !wb_ack) else $error("long ack");
	AST_ACK_IDLE: assert property (!req && clk_en |=> !wb_ack) else $error("stray ack");
	AST_FREEZE: assert property (!clk_en |=> $stable(wb_ack) && $stable(irq) && $stable(wb_dat))
		else $error("moved while frozen");
	AST_DAT_HOLD: assert property ($changed(wb_dat) |-> wb_ack) else $error("data moved");
	AST_HIGH_ZERO: assert property (wb_ack |-> wb_dat[31:8] == 24'h0) else $error("upper bits");
	AST_UNMAPPED: assert property (rd_take && wb_req.adr > csel_off |=> wb_dat == 32'h0)
		else $error("unmapped read");
	AST_CTL_SPARE: assert property (rd_take && wb_req.adr == ctl_one_off |=> wb_dat[4:3] == 2'h0)
		else $error("spare bits");
	cover property ($rose(irq));
	cover property (req && wb_req.we && wb_ack);
	cover property ($fell(clk_en));
endmodule : rtc_timer_props
`default_nettype wire

// ===== tb/rtc_timer_start_stop_read_tb_top.sv
// Self-checking bench for the real-time clock timer.
`timescale 1ns/1ps
`default_nettype none
module rtc_timer_start_stop_read_tb_top
	import rtc_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic count_tick = 1'b0;
	logic [2:0] div = 3'h0;
	wb_req_s wb_req = '0;
	logic wb_ack, irq;
	logic [31:0] wb_dat, rd;
	int err_count = 0;
	int check_count = 0;
	rtc_timer #(.busy_len(20), .tick_div(4)) i_rtc_timer (.clock(clock), .rst_n(rst_n),
		.clk_en(clk_en), .count_tick(count_tick), .wb_req(wb_req), .wb_ack(wb_ack),
		.wb_dat(wb_dat), .irq(irq));
	initial begin
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		div <= div + 3'h1;
		count_tick <= div == 3'h0;
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, m, e);
		wb_req <= '{1'b1, 1'b1, w, a, 4'h1, d};
		@(posedge clock);
		while (wb_ack !== 1'b1) @(posedge clock);
		rd = wb_dat;
		wb_req <= '0;
		@(posedge clock);
		check_count++;
		if ((rd & m) !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, rd & m, e);
		end
	endtask : bus
	task automatic ticks(input int n);
		repeat (n) @(posedge count_tick);
		@(posedge clock);
	endtask : ticks
	task automatic run_update();
		bus(1'b1, hours_off, 32'h5, 32'h0, 32'h0);
		bus(1'b1, mask_off, 32'h1, 32'h0, 32'h0);
		bus(1'b1, ctl_two_off, 32'h0, 32'h0, 32'h0);
		bus(1'b1, ctl_one_off, 32'h1, 32'h0, 32'h0);
		ticks(2);
		bus(1'b0, ctl_one_off, 32'h0, 32'h3, 32'h3);
		while (irq !== 1'b1) @(posedge clock);
		bus(1'b0, seconds_off, 32'h0, 32'hff, 32'h1);
		bus(1'b0, minutes_off, 32'h0, 32'h0, 32'h0);
		bus(1'b0, minutes_off, 32'h0, 32'hff, rd);
		bus(1'b0, status_off, 32'h0, 32'h1, 32'h1);
		bus(1'b1, status_off, 32'h3, 32'h0, 32'h0);
		check_count++;
		if (irq !== 1'b0) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, irq, 1'b0);
		end
		do bus(1'b0, ctl_one_off, 32'h0, 32'h0, 32'h0);
		while (rd[busy_bit] !== 1'b1);
		bus(1'b0, seconds_off, 32'h0, 32'hff, 32'h1);
		repeat (20) @(posedge clock);
		bus(1'b0, ctl_one_off, 32'h0, 32'h4, 32'h0);
		bus(1'b0, seconds_off, 32'h0, 32'hff, 32'h2);
	endtask : run_update
	task automatic stop_run();
		bus(1'b1, ctl_one_off, 32'h0, 32'h0, 32'h0);
		ticks(2);
		bus(1'b0, ctl_one_off, 32'h0, 32'h3, 32'h0);
		clk_en <= 1'b0;
		repeat (5) @(posedge clock);
		clk_en <= 1'b1;
		bus(1'b0, hours_off, 32'h0, 32'hff, 32'h5);
		bus(1'b0, 8'h40, 32'h0, 32'hffffffff, 32'h0);
	endtask : stop_run
	task automatic wrap_up();
		if (err_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		run_update();
		stop_run();
		wrap_up();
	end
	initial begin
		#50us;
		err_count++;
		wrap_up();
	end
endmodule : rtc_timer_start_stop_read_tb_top
bind rtc_timer rtc_timer_props i_rtc_timer_props (.clock(clock), .rst_n(rst_n),
	.clk_en(clk_en), .count_tick(count_tick), .wb_req(wb_req), .wb_ack(wb_ack),
	.wb_dat(wb_dat), .irq(irq));
`default_nettype wire
